/* hw/sewp_cfg.svh */
// Purpose: shared constants of the search engine write port
// Assumes: included by bare name from the fifo, device, host and bench files
// Notes: offsets, field positions, sizes, reset values and codes only
`ifndef SEWP_CFG_SVH
`define SEWP_CFG_SVH

// command bus codes and fields
`define SEWP_CMD_WRITE 2'h1
`define SEWP_CMD_BURST_BIT 2
`define SEWP_CMD_GMR_LSB 3
`define SEWP_CMD_SRAM_LSB 6

// address word fields on the data bus
`define SEWP_DQ_INDIRECT 29
`define SEWP_DQ_SSR_LSB 26
`define SEWP_DQ_ID_LSB 21
`define SEWP_DQ_TGT_LSB 19
`define SEWP_ID_BROADCAST 5'h1F

// internal register map (register addresses on DQ[5:0])
`define SEWP_GMR_BASE 6'h00
`define SEWP_WBC_ADDR 6'h10
`define SEWP_SSR_BASE 6'h18
`define SEWP_WBC_LEN_LSB 16
`define SEWP_REG_RESET 68'h0

// array geometry and fifo
`define SEWP_ARRAY_DEPTH 16384
`define SEWP_FIFO_DEPTH 4

// host apb register offsets
`define SEWP_APB_CTRL 12'h000
`define SEWP_APB_LEN 12'h004
`define SEWP_APB_DATA0 12'h008
`define SEWP_APB_DATA1 12'h00C
`define SEWP_APB_DATA2 12'h010
`define SEWP_APB_STATUS 12'h014

// host ctrl register fields
`define SEWP_CTRL_TGT_LSB 14
`define SEWP_CTRL_ID_LSB 16
`define SEWP_CTRL_SSR_LSB 21
`define SEWP_CTRL_IND 24
`define SEWP_CTRL_GMR_LSB 25
`define SEWP_CTRL_SRAM_LSB 28
`define SEWP_CTRL_BURST 31
`define SEWP_LEN_RESET 8'h01

`endif

/* hw/sewp_pkg.sv */
// Purpose: types shared by both ends of the write port
// Assumes: nothing
// Notes: states and target codes
package sewp_pkg;
    typedef enum logic [1:0] {
        SEWP_TGT_DATA = 2'h0,
        SEWP_TGT_MASK = 2'h1,
        SEWP_TGT_SRAM = 2'h2,
        SEWP_TGT_REG = 2'h3
    } sewp_target_t;

    typedef enum logic [1:0] {DEV_IDLE, DEV_CMD_B, DEV_DATA, DEV_TAIL} sewp_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE, HST_WAIT, HST_CMD_A, HST_CMD_B, HST_DATA, HST_TAIL
    } sewp_host_state_t;
endpackage

/* hw/sewp_if.sv */
// Purpose: wires between the host controller and the search engine
// Assumes: both ends run on the same clock
// Notes: resolves the shared data bus and end-of-transfer line
`timescale 1ns/10ps
`default_nettype none
interface sewp_if;
    logic command_valid;
    logic [8:0] cmd;
    logic [67:0] host_dq_out;
    logic host_dq_oe;
    logic eot_out;
    logic eot_oe;
    wire [67:0] dq;
    wire end_of_transfer;

    // released lines read inverted or low, never a stale word
    assign dq = host_dq_oe ? host_dq_out : ~host_dq_out;
    assign end_of_transfer = eot_oe & eot_out;

    modport device (input command_valid, input cmd, input dq, output eot_out, output eot_oe);
    modport host (output command_valid, output cmd, output host_dq_out, output host_dq_oe,
        input end_of_transfer);
endinterface
`default_nettype wire

/* hw/sewp_fifo.sv */
// Purpose: small word fifo with valid/ready on both sides
// Assumes: single clock
// Notes: full and empty are exact; level reports occupancy
`timescale 1ns/10ps
`default_nettype none
`include "sewp_cfg.svh"
module sewp_fifo #(
    parameter int WIDTH = 68,
    parameter int DEPTH = `SEWP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic push;
    logic pop;

    // handshakes straight from occupancy
    assign in_ready = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_q];

    // storage, no reset needed for data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers wrap at depth, so any depth works
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            level <= level + LW'(push) - LW'(pop);
        end
    end
endmodule
`default_nettype wire

/* hw/sewp_device.sv */
// Purpose: search engine end of the write command port
// Assumes: host keeps the command sequence; same clock as host
// Notes: arrays are plain memories; registers are a 64-word file
//
// Overview of operation
// - command bit 2 picks single or burst
// - burst hits arrays via auto-incrementing address
// - single write: two command, data, idle
// - burst of n locations lasts n+2 cycles
// - host holds valid, code, address, mask index
// - host gives upper sram address on cmd[8:6]
// - identifier match or all-ones broadcast selects
// - host drives full data word after commands
// - target field picks data, mask or sram
// - indirect address comes from status register
// - register target uses six-bit register address
// - host loads burst control before burst
// - burst ignores bus address, uses counter
// - only mask-enabled bits of arrays change
// - host supplies one word per burst cycle
// - end-of-transfer low, then high at n+1
// - end-of-transfer released after cycle n+2
// - status registers hold match address, hit

`timescale 1ns/10ps
`default_nettype none
`include "sewp_cfg.svh"
module sewp_device
    import sewp_pkg::*;
#(
    parameter int ARRAY_DEPTH = `SEWP_ARRAY_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host port
    sewp_if.device bus,
    // identity and search results
    input wire logic [4:0] device_identifier,
    input wire logic ssr_load,
    input wire logic [2:0] ssr_index,
    input wire logic [14:0] ssr_value,
    // external sram write
    output logic sram_wr_valid,
    output logic [21:0] sram_address_out,
    output logic [67:0] sram_wr_data,
    // array inspection
    input wire logic [1:0] peek_target,
    input wire logic [13:0] peek_addr,
    output logic [67:0] peek_data
);

    logic [67:0] data_mem [ARRAY_DEPTH];
    logic [67:0] mask_mem [ARRAY_DEPTH];
    logic [67:0] regs_q [64];

    // sequencer and held command fields
    sewp_dev_state_t st_q;
    logic burst_q;
    logic sel_q;
    sewp_target_t tgt_q;
    logic [2:0] gmr_idx_q;
    logic [2:0] sram_hi_q;
    logic [13:0] addr_q;
    logic [5:0] reg_addr_q;
    logic [7:0] len_q;
    logic [7:0] cnt_q;

    // views of registers and bus
    logic [67:0] wbc;
    logic [67:0] ssr_sel;
    logic [67:0] global_mask_register;

    logic id_hit;
    logic in_data;
    logic last;

    // status register address view, used only for the indirect address
    function automatic logic [13:0] ssr_address(input logic [67:0] search_status_register, input logic [1:0] lo);
        ssr_address = {search_status_register[13:2], search_status_register[1] | lo[1], search_status_register[0] | lo[0]};
    endfunction

    assign wbc = regs_q[`SEWP_WBC_ADDR];
    assign ssr_sel = regs_q[`SEWP_SSR_BASE + 6'(bus.dq[`SEWP_DQ_SSR_LSB +: 3])];
    assign global_mask_register = regs_q[`SEWP_GMR_BASE + 6'(gmr_idx_q)];
    assign id_hit = (bus.dq[`SEWP_DQ_ID_LSB +: 5] == device_identifier) ||
        (bus.dq[`SEWP_DQ_ID_LSB +: 5] == `SEWP_ID_BROADCAST);

    // data cycles of a selected device
    assign in_data = (st_q == DEV_DATA) && sel_q;
    assign last = (cnt_q == len_q - 8'h01);

    // command sequencer: 1A, 1B, n data cycles, one idle cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= DEV_IDLE;
            cnt_q <= 8'h00;
        end else begin
            unique case (st_q)
                DEV_IDLE: begin
                    if (bus.command_valid && bus.cmd[1:0] == `SEWP_CMD_WRITE) begin
                        st_q <= DEV_CMD_B;
                    end
                end
                DEV_CMD_B: begin
                    st_q <= DEV_DATA;
                    cnt_q <= 8'h00;
                end
                DEV_DATA: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (last) begin
                        st_q <= DEV_TAIL;
                    end
                end
                DEV_TAIL: begin
                    st_q <= DEV_IDLE;
                end
            endcase
        end
    end

    // capture of command and address fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            burst_q <= 1'b0;
            sel_q <= 1'b0;
            tgt_q <= SEWP_TGT_DATA;
            gmr_idx_q <= 3'h0;
            sram_hi_q <= 3'h0;
            addr_q <= 14'h0000;
            reg_addr_q <= 6'h00;
            len_q <= 8'h01;
        end else if (st_q == DEV_IDLE && bus.command_valid) begin
            burst_q <= bus.cmd[`SEWP_CMD_BURST_BIT];
            gmr_idx_q <= bus.cmd[`SEWP_CMD_GMR_LSB +: 3];
            sram_hi_q <= bus.cmd[`SEWP_CMD_SRAM_LSB +: 3];
        end else if (st_q == DEV_CMD_B) begin
            // the address word stands on the bus in 1B
            tgt_q <= sewp_target_t'(bus.dq[`SEWP_DQ_TGT_LSB +: 2]);
            reg_addr_q <= bus.dq[5:0];
            // burst only reaches the two arrays
            sel_q <= id_hit && !(burst_q && bus.dq[`SEWP_DQ_TGT_LSB + 1]);
            if (burst_q) begin
                addr_q <= wbc[13:0];
                len_q <= (wbc[`SEWP_WBC_LEN_LSB +: 8] == 8'h00) ? 8'h01 :
                    wbc[`SEWP_WBC_LEN_LSB +: 8];
            end else begin
                len_q <= 8'h01;
                addr_q <= bus.dq[`SEWP_DQ_INDIRECT] ? ssr_address(ssr_sel, bus.dq[1:0]) :
                    bus.dq[13:0];
            end
        end else if (in_data && burst_q) begin
            addr_q <= addr_q + 14'h0001;
        end
    end

    // masked array writes, one location per data cycle
    always_ff @(posedge clk) begin
        if (in_data && tgt_q == SEWP_TGT_DATA) begin
            data_mem[addr_q] <= (data_mem[addr_q] & ~global_mask_register) | (bus.dq & global_mask_register);
        end
        if (in_data && tgt_q == SEWP_TGT_MASK) begin
            mask_mem[addr_q] <= (mask_mem[addr_q] & ~global_mask_register) | (bus.dq & global_mask_register);
        end
        peek_data <= (peek_target == SEWP_TGT_MASK) ? mask_mem[peek_addr] :
            data_mem[peek_addr];
    end

    // register file; a search result load wins over a host write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                regs_q[i] <= `SEWP_REG_RESET;
            end
        end else begin
            if (in_data && !burst_q && tgt_q == SEWP_TGT_REG) begin
                regs_q[reg_addr_q] <= bus.dq;
            end
            if (ssr_load) begin
                regs_q[`SEWP_SSR_BASE + 6'(ssr_index)] <= {53'h0, ssr_value};
            end
        end
    end

    // sram write strobe with the composed address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sram_wr_valid <= 1'b0;
            sram_address_out <= 22'h000000;
            sram_wr_data <= 68'h0;
        end else begin
            sram_wr_valid <= in_data && !burst_q && tgt_q == SEWP_TGT_SRAM;
            if (in_data && !burst_q && tgt_q == SEWP_TGT_SRAM) begin
                sram_address_out <= {sram_hi_q, 5'h00, addr_q};
                sram_wr_data <= bus.dq;
            end
        end
    end

    // end-of-transfer: driven from cycle 3 (or n+1) through n+2, high only at n+1
    // single writes and unselected devices leave it released
    assign bus.eot_oe = burst_q && sel_q &&
        ((st_q == DEV_DATA && (cnt_q != 8'h00 || last)) || st_q == DEV_TAIL);
    assign bus.eot_out = burst_q && sel_q && st_q == DEV_DATA && last;
endmodule
`default_nettype wire

/* hw/sewp_host.sv */
// Purpose: host controller issuing write commands, driven over apb
// Assumes: software fills the fifo before a long burst
// Notes: a word written to DATA2 pushes {DATA2,DATA1,DATA0}
`timescale 1ns/10ps
`default_nettype none
`include "sewp_cfg.svh"
module sewp_host
    import sewp_pkg::*;
#(
    parameter int FIFO_DEPTH = `SEWP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // search engine port
    sewp_if.host bus
);
    localparam int LW = $clog2(FIFO_DEPTH+1);
    sewp_host_state_t st_q;
    logic [31:0] ctrl_q;
    logic [7:0] len_q;
    logic [31:0] d0_q;
    logic [31:0] d1_q;
    logic [7:0] cnt_q;
    logic underrun_q;
    logic eot_seen_q;
    logic access;
    logic push;
    logic pop;
    logic f_ready;
    logic f_valid;
    logic [67:0] f_data;
    logic [LW-1:0] f_level;
    logic [7:0] need;
    logic mapped;

    // apb decode; a push stalls while the fifo is full
    assign access = psel && penable;
    assign mapped = (paddr == `SEWP_APB_CTRL) || (paddr == `SEWP_APB_LEN) ||
        (paddr == `SEWP_APB_DATA0) || (paddr == `SEWP_APB_DATA1) ||
        (paddr == `SEWP_APB_DATA2) || (paddr == `SEWP_APB_STATUS);
    assign pready = !(pwrite && paddr == `SEWP_APB_DATA2 && !f_ready);
    assign pslverr = access && (!mapped || (pwrite && paddr == `SEWP_APB_CTRL &&
        st_q != HST_IDLE));
    assign push = access && pready && pwrite && paddr == `SEWP_APB_DATA2;
    assign need = (len_q > 8'(FIFO_DEPTH)) ? 8'(FIFO_DEPTH) : len_q;

    // read mux over flops
    always_comb begin
        prdata = 32'h00000000;
        unique case (paddr)
            `SEWP_APB_CTRL: prdata = ctrl_q;
            `SEWP_APB_LEN: prdata = {24'h000000, len_q};
            `SEWP_APB_DATA0: prdata = d0_q;
            `SEWP_APB_DATA1: prdata = d1_q;
            `SEWP_APB_STATUS: prdata = {16'h0000, 8'(f_level), 5'h00, eot_seen_q, underrun_q,
                st_q != HST_IDLE};
            default: prdata = 32'h00000000;
        endcase
    end

    // software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= 32'h00000000;
            len_q <= `SEWP_LEN_RESET;
            d0_q <= 32'h00000000;
            d1_q <= 32'h00000000;
        end else if (access && pwrite) begin
            if (paddr == `SEWP_APB_CTRL && st_q == HST_IDLE) begin
                ctrl_q <= pwdata;
            end
            if (paddr == `SEWP_APB_LEN && st_q == HST_IDLE) begin
                len_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            end
            if (paddr == `SEWP_APB_DATA0) begin
                d0_q <= pwdata;
            end
            if (paddr == `SEWP_APB_DATA1) begin
                d1_q <= pwdata;
            end
        end
    end

    // data words queue up ahead of the command
    sewp_fifo #(.WIDTH(68), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(f_ready),
        .in_data({pwdata[3:0], d1_q, d0_q}),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data),
        .level(f_level)
    );

    // one word leaves per data cycle
    assign pop = (st_q == HST_CMD_B) || (st_q == HST_DATA && cnt_q != len_q - 8'h01);

    // command sequencer: A, B, data words, idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= HST_IDLE;
            cnt_q <= 8'h00;
            bus.command_valid <= 1'b0;
            bus.cmd <= 9'h000;
            bus.host_dq_out <= 68'h0;
            bus.host_dq_oe <= 1'b0;
        end else begin
            unique case (st_q)
                HST_IDLE: begin
                    if (access && pwrite && paddr == `SEWP_APB_CTRL) begin
                        st_q <= HST_WAIT;
                    end
                end
                HST_WAIT: begin
                    if (f_level >= LW'(need)) begin
                        st_q <= HST_CMD_A;
                        bus.command_valid <= 1'b1;
                        bus.cmd <= {ctrl_q[`SEWP_CTRL_SRAM_LSB +: 3], ctrl_q[`SEWP_CTRL_GMR_LSB +: 3],
                            ctrl_q[`SEWP_CTRL_BURST], `SEWP_CMD_WRITE};
                        bus.host_dq_out <= {38'h0, ctrl_q[`SEWP_CTRL_IND],
                            ctrl_q[`SEWP_CTRL_SSR_LSB +: 3], ctrl_q[`SEWP_CTRL_ID_LSB +: 5],
                            ctrl_q[`SEWP_CTRL_TGT_LSB +: 2], 5'h00, ctrl_q[13:0]};
                        bus.host_dq_oe <= 1'b1;
                    end
                end
                HST_CMD_A: begin
                    st_q <= HST_CMD_B;
                end
                HST_CMD_B: begin
                    st_q <= HST_DATA;
                    cnt_q <= 8'h00;
                    bus.command_valid <= 1'b0;
                    bus.host_dq_out <= f_data;
                end
                HST_DATA: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == len_q - 8'h01) begin
                        st_q <= HST_TAIL;
                        bus.host_dq_oe <= 1'b0;
                    end else begin
                        bus.host_dq_out <= f_data;
                    end
                end
                HST_TAIL: begin
                    st_q <= HST_IDLE;
                end
                default: st_q <= HST_IDLE;
            endcase
        end
    end

    // sticky status; cleared by the next start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            underrun_q <= 1'b0;
            eot_seen_q <= 1'b0;
        end else if (st_q == HST_IDLE && access && pwrite && paddr == `SEWP_APB_CTRL) begin
            underrun_q <= 1'b0;
            eot_seen_q <= 1'b0;
        end else begin
            if (pop && !f_valid) begin
                underrun_q <= 1'b1;
            end
            if (st_q == HST_DATA && bus.end_of_transfer == 1'b1) begin
                eot_seen_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/sewp_properties.sv */
// Purpose: timing checks on the port between host and engine ends
// Assumes: one clock, rst asynchronous and active high
// Notes: sees only the shared port wires, never the bench drivers
`timescale 1ns/10ps
`default_nettype none
module sewp_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // port wires
    input wire logic command_valid,
    input wire logic [8:0] cmd,
    input wire logic host_dq_oe,
    input wire logic eot_out,
    input wire logic eot_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // command phase: exactly two cycles, host driving the bus, write code
    property p_cmd_two; $rose(command_valid) |=> command_valid ##1 !command_valid; endproperty
    property p_cmd_dq; command_valid |-> host_dq_oe && cmd[1:0] == 2'h1; endproperty
    property p_cmd_stable; $rose(command_valid) |=> $stable(cmd); endproperty
    // data cycle follows the commands; single write ends with an idle cycle
    property p_data_cyc; $fell(command_valid) |-> host_dq_oe; endproperty
    property p_single_idle; $fell(command_valid) && !$past(cmd[2]) |=> !host_dq_oe; endproperty
    property p_single_no_eot;
        $fell(command_valid) && !$past(cmd[2]) |-> !eot_oe ##1 !eot_oe;
    endproperty
    // end-of-transfer: one high cycle with the last word, low, then released
    property p_eot_pulse; eot_oe && eot_out |=> eot_oe && !eot_out ##1 !eot_oe; endproperty
    property p_eot_last; eot_oe && eot_out |-> host_dq_oe && !command_valid ##1 !host_dq_oe;
    endproperty
    property p_eot_low; eot_oe && !eot_out && host_dq_oe |=> eot_oe; endproperty
    // nothing new starts while the previous operation still owns the port
    property p_new_cmd; $rose(command_valid) |-> !eot_oe; endproperty

    a_cmd_two: assert property (p_cmd_two) else $error("command phase length wrong");
    a_cmd_dq: assert property (p_cmd_dq) else $error("command cycle content wrong");
    a_cmd_stable: assert property (p_cmd_stable) else $error("command changed in B");
    a_data_cyc: assert property (p_data_cyc) else $error("no data after commands");
    a_single_idle: assert property (p_single_idle) else $error("no idle cycle");
    a_single_no_eot: assert property (p_single_no_eot) else $error("eot on single");
    a_eot_pulse: assert property (p_eot_pulse) else $error("eot end wrong");
    a_eot_last: assert property (p_eot_last) else $error("eot not with last word");
    a_eot_low: assert property (p_eot_low) else $error("eot dropped early");
    a_new_cmd: assert property (p_new_cmd) else $error("command during burst");

    c_single: cover property ($fell(command_valid) && !$past(cmd[2]));
    c_burst: cover property ($rose(command_valid) && cmd[2]);
    c_eot: cover property (eot_oe && eot_out);
endmodule
`default_nettype wire

/* verification/search_engine_write_port_tb.sv */
// Purpose: drives host over apb, engine answers across the shared port
// Assumes: engine identifier tied to one value; masks loaded first
// Notes: array contents read back through the peek port
`timescale 1ns/10ps
`default_nettype none
`include "sewp_cfg.svh"
module search_engine_write_port_tb import sewp_pkg::*;;
    localparam logic [4:0] MY_ID = 5'h05;
    localparam logic [67:0] M1 = 68'h0_0000_0000_FFFF_FFFF;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic ssr_load = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] ssr_index = 3'h0;
    logic [14:0] ssr_value = 15'h0;
    logic [1:0] peek_target = 2'h0;
    logic [13:0] peek_addr = 14'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sram_wr_valid, err;
    logic [21:0] sram_address_out;
    logic [67:0] sram_wr_data, peek_data;
    int n_mismatch = 0, num_checks = 0, cyc = 0, n_oe = 0, n_hi = 0, n_sram = 0;

    sewp_if u_sewp_if ();
    sewp_host u_sewp_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(u_sewp_if));
    sewp_device u_sewp_device (.clk(clk), .rst(rst), .bus(u_sewp_if),
        .device_identifier(MY_ID), .ssr_load(ssr_load), .ssr_index(ssr_index),
        .ssr_value(ssr_value), .sram_wr_valid(sram_wr_valid),
        .sram_address_out(sram_address_out), .sram_wr_data(sram_wr_data),
        .peek_target(peek_target), .peek_addr(peek_addr), .peek_data(peek_data));
    sewp_properties u_sewp_properties (.clk(clk), .rst(rst),
        .command_valid(u_sewp_if.command_valid), .cmd(u_sewp_if.cmd),
        .host_dq_oe(u_sewp_if.host_dq_oe), .eot_out(u_sewp_if.eot_out),
        .eot_oe(u_sewp_if.eot_oe));

    always #5 clk = ~clk;

    // wire activity counters and the hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (u_sewp_if.eot_oe === 1'h1) n_oe <= n_oe + 1;
        if (u_sewp_if.end_of_transfer === 1'h1) n_hi <= n_hi + 1;
        if (sram_wr_valid === 1'h1) n_sram <= n_sram + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [67:0] s, input logic [67:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // one apb transfer; holds everything until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [31:0] ctl(input logic b, input logic [2:0] s, input logic [2:0] g,
        input logic i, input logic [2:0] x, input logic [4:0] id, input logic [1:0] t,
        input logic [13:0] a);
        return {b, s, g, i, x, id, t, a};
    endfunction

    task automatic push(input logic [67:0] w);
        apb(1'h1, `SEWP_APB_DATA0, w[31:0]);
        apb(1'h1, `SEWP_APB_DATA1, w[63:32]);
        apb(1'h1, `SEWP_APB_DATA2, {28'h0, w[67:64]});
    endtask

    // busy is polled with a bound; the global guard catches the rest
    task automatic wait_idle();
        for (int k = 0; k < 100; k++) begin
            apb(1'h0, `SEWP_APB_STATUS, 32'h0);
            if (rd[0] === 1'h0) break;
        end
    endtask

    task automatic issue(input logic [67:0] w, input logic [31:0] c);
        apb(1'h1, `SEWP_APB_LEN, 32'h1);
        push(w);
        apb(1'h1, `SEWP_APB_CTRL, c);
        wait_idle();
    endtask

    // peek data lands one cycle after the address
    task automatic peek(input logic [1:0] t, input logic [13:0] a, input logic [67:0] e);
        @(posedge clk);
        peek_target <= t;
        peek_addr <= a;
        repeat (2) @(posedge clk);
        chk(peek_data, e);
    endtask

    task automatic t_regs();
        apb(1'h0, `SEWP_APB_LEN, 32'h0);
        chk({36'h0, rd}, 68'h1);
        apb(1'h0, 12'h040, 32'h0);
        chk({67'h0, err}, 68'h1);
    endtask

    // masks first: reset masks of zero would block every array write
    task automatic t_single();
        issue(68'hF_FFFF_FFFF_FFFF_FFFF, ctl(0, 0, 0, 0, 0, MY_ID, 2'h3, 14'h0000));
        issue(M1, ctl(0, 0, 0, 0, 0, MY_ID, 2'h3, 14'h0001));
        issue(68'hA_1111_2222_3333_4444, ctl(0, 0, 3'h0, 0, 0, MY_ID, 2'h0, 14'h0005));
        issue(68'h5_CCCC_DDDD_EEEE_FFFF, ctl(0, 0, 3'h1, 0, 0, MY_ID, 2'h0, 14'h0005));
        peek(2'h0, 14'h0005, 68'hA_1111_2222_EEEE_FFFF);
        issue(68'h3_0000_0000_0000_0077, ctl(0, 0, 3'h0, 0, 0, MY_ID, 2'h1, 14'h0005));
        peek(2'h1, 14'h0005, 68'h3_0000_0000_0000_0077);
    endtask

    task automatic t_indirect();
        @(posedge clk);
        ssr_index <= 3'h2;
        ssr_value <= 15'h4104;
        ssr_load <= 1'h1;
        @(posedge clk);
        ssr_load <= 1'h0;
        issue(68'h5_0000_0000_0000_0ABC, ctl(0, 0, 0, 1, 3'h2, MY_ID, 2'h0, 14'h0001));
        peek(2'h0, 14'h0105, 68'h5_0000_0000_0000_0ABC);
    endtask

    task automatic t_ids();
        issue(68'h1_2345_6789_ABCD_EF01, ctl(0, 0, 0, 0, 0, 5'h1F, 2'h0, 14'h0009));
        peek(2'h0, 14'h0009, 68'h1_2345_6789_ABCD_EF01);
        issue(68'h0_0000_0000_0000_0000, ctl(0, 0, 0, 0, 0, 5'h03, 2'h0, 14'h0009));
        peek(2'h0, 14'h0009, 68'h1_2345_6789_ABCD_EF01);
    endtask

    task automatic t_sram();
        int k;
        k = n_sram;
        issue(68'h7_0000_0000_0000_0042, ctl(0, 3'h5, 0, 0, 0, MY_ID, 2'h2, 14'h0123));
        chk(68'(n_sram - k), 68'h1);
        chk({46'h0, sram_address_out}, {46'h0, 3'h5, 5'h00, 14'h0123});
        chk(sram_wr_data, 68'h7_0000_0000_0000_0042);
    endtask

    // four-word burst from 0x20; the bus address field is deliberately wrong
    task automatic burst(input logic [4:0] id, input logic [67:0] w, input logic [67:0] e,
        input int n_eot);
        int o;
        int h;
        issue(68'h0004_0020, ctl(0, 0, 0, 0, 0, id, 2'h3, 14'h0010));
        apb(1'h1, `SEWP_APB_LEN, 32'h4);
        for (int k = 0; k < 4; k++) push(w + 68'(k));
        apb(1'h0, `SEWP_APB_STATUS, 32'h0);
        chk(68'(rd[15:8]), 68'h4);
        o = n_oe;
        h = n_hi;
        apb(1'h1, `SEWP_APB_CTRL, ctl(1, 0, 0, 0, 0, id, 2'h0, 14'h3FFF));
        wait_idle();
        chk(68'(rd[2:1]), 68'(n_eot / 2));
        repeat (2) @(posedge clk);
        chk(68'(n_oe - o), 68'(n_eot));
        chk(68'(n_hi - h), 68'(n_eot / 4));
        for (int k = 0; k < 4; k++) peek(2'h0, 14'h0020 + 14'(k), e + 68'(k));
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_single();
        t_indirect();
        t_ids();
        t_sram();
        burst(MY_ID, 68'h9_0000_0000_0000_0100, 68'h9_0000_0000_0000_0100, 4);
        burst(5'h03, 68'h2_0000_0000_0000_0200, 68'h9_0000_0000_0000_0100, 0);
        test_done();
    end
endmodule
`default_nettype wire
